// ---- core/ccp_config_ctrl.sv ----
// Configuration control pin logic: restart, strap latching, strobe clock, start-up, readback.
// Assumes pins are asynchronous to clk_sys; open-drain pins have external pull-ups.
//
// Functional notes
// - Reset during configuration abandons the load and restarts configuration.
// - After configuration, reset asynchronously clears all logic cell flip-flops.
// - In master and asynchronous peripheral modes the device drives the strobe clock.
// - In microprocessor and PCI modes the strobe clock is made inside and driven out.
// - Start-up waits while the done pin is held low from outside.
// - Done is released high by open drain when configuration ends and feeds core start-up.
// - Program low restarts configuration and resets boundary scan.
// - Readback trigger low during configuration puts every I/O in high impedance.
// - After configuration a trigger falling edge starts readback at frame 0 if enabled, else 3-states.
// - Readback data goes out on the dual pin, which carries test data when scan uses it.
// - Mode pins are latched on the rising edge of the wait pin.
// - The speed pin is latched on that edge: low 10 MHz, high 1.25 MHz.
// - User I/Os stay high impedance with pull-ups throughout configuration.
// - Unused configuration pins stay high impedance with pull-ups after configuration.
// - The wait pin is driven low while clearing, and an external low holds off configuration.
`timescale 1ns/100ps
module ccp_config_ctrl
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic resetPin,
  input wire logic program_restart_n,
  input wire logic initIn,
  output logic initOut,
  output logic initOe,
  input wire logic config_mode_bit_a,
  input wire logic config_mode_bit_b,
  input wire logic config_mode_bit_c,
  input wire logic oscillator_speed_sel,
  input wire logic strobeIn,
  output logic strobeOut,
  output logic strobeOe,
  input wire logic doneIn,
  output logic doneOut,
  output logic doneOe,
  input wire logic loadComplete,
  input wire logic readbackTrigger_n,
  input wire logic readbackEnable,
  input wire logic scanSelect,
  input wire logic scanTdo,
  input wire logic readbackBit,
  output logic readbackData,
  output logic [ccp_pkg::FRAME_W-1:0] readbackFrame,
  output logic readbackActive,
  output logic strobeEdge,
  output logic cellClear_n,
  output logic scanReset,
  output logic global_tristate,
  output logic userIoPullup,
  output logic unusedPinPullup,
  output logic configDone,
  output logic [2:0] latchedMode,
  output logic slowOsc
);
  // Synchronisers: stage one feeds only stage two; reset to each pin's idle level
  localparam int NS = 10;
  localparam logic [NS-1:0] SYNC_IDLE = 10'h31F;
  logic [NS-1:0] rawIn, syncA_q, syncB_q;
  assign rawIn = {resetPin, program_restart_n, initIn, strobeIn, doneIn, readbackTrigger_n,
    config_mode_bit_c, config_mode_bit_b, config_mode_bit_a, oscillator_speed_sel};
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA_q <= SYNC_IDLE;
      syncB_q <= SYNC_IDLE;
    end
    else
    begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
    end
  end
  logic rstS, prgS, initS, strS, doneS, trigS, modeCS, modeBS, modeAS, oscS;
  assign {rstS, prgS, initS, strS, doneS, trigS, modeCS, modeBS, modeAS, oscS} = syncB_q;

  ccp_pkg::ccp_state_t state_q, state_d;
  logic [6:0] clrCnt_q, clrCnt_d;
  localparam int DIV_W_L = ccp_pkg::DIV_W;
  logic [DIV_W_L-1:0] div_q, div_d;
  logic stb_q, stb_d, strPrev_q, trigPrev_q, initPrev_q;
  ccp_pkg::ccp_strap_t strap_q, strap_d;
  logic rbAct_q, rbAct_d, rbData_q, rbData_d;
  logic [ccp_pkg::FRAME_W-1:0] frame_q, frame_d;
  logic drive, restart, initRise, trigFall, extEdge;

  if (ccp_pkg::HALF_SLOW >= (1 << ccp_pkg::DIV_W) || ccp_pkg::HALF_FAST < 1)
  begin : g_divCheck
    $error("Strobe divider width too small");
  end

  assign restart = (!rstS && state_q != ccp_pkg::ST_USER) || !prgS;
  assign initRise = initS && !initPrev_q;
  assign trigFall = !trigS && trigPrev_q;
  // Master, asynchronous peripheral, microprocessor and PCI modes drive the strobe clock
  assign drive = !(strap_q.modeC && strap_q.modeB && strap_q.modeA)
    && ({strap_q.modeC, strap_q.modeB, strap_q.modeA} != ccp_pkg::MODE_SYNC_PERIPH)
    && ({strap_q.modeC, strap_q.modeB, strap_q.modeA} != ccp_pkg::MODE_SLAVE_PAR);
  assign extEdge = strS && !strPrev_q;

  always_comb
  begin
    state_d = state_q;
    clrCnt_d = clrCnt_q;
    div_d = div_q;
    stb_d = stb_q;
    strap_d = strap_q;
    rbAct_d = rbAct_q;
    rbData_d = rbData_q;
    frame_d = frame_q;
    strobeEdge = 1'b0;
    if (restart)
    begin
      state_d = ccp_pkg::ST_CLEAR;
      clrCnt_d = 7'h00;
      stb_d = 1'b0;
      div_d = '0;
      rbAct_d = 1'b0;
    end
    else
    begin
      unique case (state_q)
        ccp_pkg::ST_CLEAR:
        begin
          clrCnt_d = clrCnt_q + 7'h01;
          if (clrCnt_q == 7'(ccp_pkg::CLEAR_CYCLES - 1))
            state_d = ccp_pkg::ST_WAIT;
        end
        ccp_pkg::ST_WAIT:
        begin
          if (initRise)
          begin
            strap_d = '{modeA: modeAS, modeB: modeBS, modeC: modeCS, oscSel: oscS};
            state_d = ccp_pkg::ST_LOAD;
          end
        end
        ccp_pkg::ST_LOAD:
        begin
          if (drive)
          begin
            if (div_q == DIV_W_L'((strap_q.oscSel ? ccp_pkg::HALF_SLOW : ccp_pkg::HALF_FAST) - 1))
            begin
              div_d = '0;
              stb_d = !stb_q;
              strobeEdge = !stb_q;
            end
            else
              div_d = div_q + DIV_W_L'(1);
          end
          else
            strobeEdge = extEdge;
          if (loadComplete)
            state_d = ccp_pkg::ST_HOLD;
        end
        ccp_pkg::ST_HOLD:
        begin
          stb_d = 1'b0;
          if (doneS)
            state_d = ccp_pkg::ST_USER;
        end
        ccp_pkg::ST_USER:
        begin
          if (readbackEnable && trigFall)
          begin
            rbAct_d = 1'b1;
            frame_d = ccp_pkg::FRAME_START;
          end
          else if (rbAct_q && extEdge)
          begin
            rbData_d = readbackBit;
            frame_d = frame_q + {{(ccp_pkg::FRAME_W-1){1'b0}}, 1'b1};
          end
        end
        default: state_d = ccp_pkg::ST_CLEAR;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ccp_pkg::ST_CLEAR;
      clrCnt_q <= 7'h00;
      div_q <= '0;
      stb_q <= 1'b0;
      strap_q <= '0;
      rbAct_q <= 1'b0;
      rbData_q <= 1'b0;
      frame_q <= '0;
      strPrev_q <= 1'b0;
      trigPrev_q <= 1'b1;
      initPrev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      clrCnt_q <= clrCnt_d;
      div_q <= div_d;
      stb_q <= stb_d;
      strap_q <= strap_d;
      rbAct_q <= rbAct_d;
      rbData_q <= rbData_d;
      frame_q <= frame_d;
      strPrev_q <= strS;
      trigPrev_q <= trigS;
      initPrev_q <= initS;
    end
  end

  logic inConfig;
  assign inConfig = state_q != ccp_pkg::ST_USER;
  assign initOut = 1'b0;
  assign initOe = state_q == ccp_pkg::ST_CLEAR;
  assign strobeOut = stb_q;
  assign strobeOe = drive && state_q == ccp_pkg::ST_LOAD;
  assign doneOut = 1'b0;
  assign doneOe = state_q != ccp_pkg::ST_HOLD && inConfig;
  assign configDone = !inConfig;
  assign cellClear_n = inConfig || rstS;
  assign scanReset = !prgS;
  assign global_tristate = inConfig ? !trigS : (!readbackEnable && !trigS);
  assign userIoPullup = inConfig;
  assign unusedPinPullup = 1'b1;
  assign readbackData = scanSelect ? scanTdo : rbData_q;
  assign readbackFrame = frame_q;
  assign readbackActive = rbAct_q;
  assign latchedMode = {strap_q.modeC, strap_q.modeB, strap_q.modeA};
  assign slowOsc = strap_q.oscSel;

  property p_restart;
    @(posedge clk_sys) disable iff (!reset_n)
    !prgS |=> state_q == ccp_pkg::ST_CLEAR;
  endproperty
  a_restart: assert property (p_restart) else $error("Program did not restart");

  property p_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    state_q == ccp_pkg::ST_HOLD && !doneS && prgS && rstS |=> state_q == ccp_pkg::ST_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("Start-up not held by done");

  property p_tri;
    @(posedge clk_sys) disable iff (!reset_n)
    inConfig && !trigS |-> global_tristate;
  endproperty
  a_tri: assert property (p_tri) else $error("Trigger low did not 3-state");

  property p_frame;
    @(posedge clk_sys) disable iff (!reset_n)
    state_q == ccp_pkg::ST_USER && readbackEnable && trigFall && prgS |=> rbAct_q && frame_q == ccp_pkg::FRAME_START;
  endproperty
  a_frame: assert property (p_frame) else $error("Readback did not start at frame 0");

  property p_strap;
    @(posedge clk_sys) disable iff (!reset_n)
    state_q == ccp_pkg::ST_WAIT && initRise && prgS && rstS |=> slowOsc == $past(oscS);
  endproperty
  a_strap: assert property (p_strap) else $error("Speed select not latched");

  property p_mode;
    @(posedge clk_sys) disable iff (!reset_n)
    state_q == ccp_pkg::ST_WAIT && initRise && prgS && rstS |=> latchedMode == $past({modeCS, modeBS, modeAS});
  endproperty
  a_mode: assert property (p_mode) else $error("Mode not latched");

  property p_strobe;
    @(posedge clk_sys) disable iff (!reset_n)
    strobeOe && !strap_q.oscSel && $rose(stb_q) |-> ##[1:12] !stb_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("Fast strobe too slow");

  property p_pull;
    @(posedge clk_sys) disable iff (!reset_n)
    inConfig |-> userIoPullup && !configDone;
  endproperty
  a_pull: assert property (p_pull) else $error("User I/O not pulled up");
endmodule

// ---- common/ccp_pkg.sv ----
// Package for the configuration control pin block: modes, states, timing counts.
// Assumes a 250 MHz system clock.
package ccp_pkg;
  localparam int CLK_MHZ = 250;
  // Internal configuration oscillator rates, kHz
  localparam int OSC_FAST_KHZ = 10000;
  localparam int OSC_SLOW_KHZ = 1250;
  // Half periods of the strobe clock in system cycles (rounded down, at least one)
  localparam int HALF_FAST = (CLK_MHZ * 1000) / (2 * OSC_FAST_KHZ);
  localparam int HALF_SLOW = (CLK_MHZ * 1000) / (2 * OSC_SLOW_KHZ);
  localparam int DIV_W = 8;
  localparam int CLEAR_CYCLES = 64;
  localparam int FRAME_W = 16;
  localparam logic [FRAME_W-1:0] FRAME_START = 16'h0000;

  // Mode pins {c,b,a}
  localparam logic [2:0] MODE_SLAVE_SER = 3'h7;
  localparam logic [2:0] MODE_SYNC_PERIPH = 3'h3;
  localparam logic [2:0] MODE_SLAVE_PAR = 3'h6;
  localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h5;
  localparam logic [2:0] MODE_MICRO = 3'h2;
  localparam logic [2:0] MODE_PCI = 3'h1;

  typedef enum logic [4:0] {
    ST_CLEAR = 5'h01,
    ST_WAIT = 5'h02,
    ST_LOAD = 5'h04,
    ST_HOLD = 5'h08,
    ST_USER = 5'h10
  } ccp_state_t;

  typedef struct packed {
    logic modeA;
    logic modeB;
    logic modeC;
    logic oscSel;
  } ccp_strap_t;

  typedef struct packed {
    logic out;
    logic oe;
  } ccp_drive_t;
endpackage

// ---- tb/ccp_host_model.sv ----
// Host model: external strobe clock source and readback trigger driver.
// Assumes the bench resolves the open-drain wait pin into initPin.
`timescale 1ns/100ps
module ccp_host_model
(
  input wire logic strobeRun,
  input wire logic initPin,
  input wire logic trigReq_n,
  output logic strobeClk,
  output logic trig_n
);
  initial strobeClk = 1'b0;
  // Runs only while strobeRun is high, 80 ns period
  always #40 strobeClk = strobeRun ? ~strobeClk : 1'b0;
  assign trig_n = trigReq_n | (initPin !== 1'b1);
endmodule

// ---- tb/ccp_config_ctrl_test.sv ----
// Bench for the configuration control pins: restart, straps, strobe clock, done, readback.
// Assumes ccp_pkg and the host model are compiled first.
`timescale 1ns/100ps
module ccp_config_ctrl_test;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic resetPin = 1'b1;
  logic program_restart_n = 1'b1;
  logic initHold = 1'b0;
  logic doneHold = 1'b0;
  logic hostRun = 1'b0;
  logic trigReq_n = 1'b1;
  logic loadComplete = 1'b0;
  logic readbackEnable = 1'b0;
  logic scanSelect = 1'b0;
  logic scanTdo = 1'b0;
  logic readbackBit = 1'b1;
  ccp_pkg::ccp_strap_t strap = '0;
  logic initIn, initOut, initOe, strobeIn, strobeOut, strobeOe, hostClk, doneIn, doneOut, doneOe, trig_n;
  logic readbackData, readbackActive, strobeEdge, cellClear_n, scanReset, global_tristate;
  logic userIoPullup, unusedPinPullup, configDone, slowOsc;
  logic [2:0] latchedMode;
  logic [ccp_pkg::FRAME_W-1:0] readbackFrame;
  int err_total = 0;
  int checks_done = 0;
  int edgeCnt = 0;
  int edgeBase;
  logic [2:0] modes [6] = '{ccp_pkg::MODE_SLAVE_SER, ccp_pkg::MODE_MICRO, ccp_pkg::MODE_PCI,
    ccp_pkg::MODE_SYNC_PERIPH, ccp_pkg::MODE_SLAVE_PAR, ccp_pkg::MODE_ASYNC_PERIPH};

  // Open-drain wait and done pins with pull-ups; strobe pin from the DUT when it drives, else the host
  assign initIn = ~(initOe & ~initOut) & ~initHold;
  assign doneIn = ~(doneOe & ~doneOut) & ~doneHold;
  assign strobeIn = strobeOe ? strobeOut : hostClk;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) edgeCnt <= edgeCnt + int'(strobeEdge);

  ccp_host_model i_host (.strobeRun(hostRun), .initPin(initIn), .trigReq_n, .strobeClk(hostClk), .trig_n);

  ccp_config_ctrl i_dut (.clk_sys, .reset_n, .resetPin, .program_restart_n, .initIn, .initOut, .initOe,
    .config_mode_bit_a(strap.modeA), .config_mode_bit_b(strap.modeB), .config_mode_bit_c(strap.modeC),
    .oscillator_speed_sel(strap.oscSel), .strobeIn, .strobeOut, .strobeOe, .doneIn, .doneOut, .doneOe,
    .loadComplete, .readbackTrigger_n(trig_n), .readbackEnable, .scanSelect, .scanTdo, .readbackBit,
    .readbackData, .readbackFrame, .readbackActive, .strobeEdge, .cellClear_n, .scanReset, .global_tristate,
    .userIoPullup, .unusedPinPullup, .configDone, .latchedMode, .slowOsc);

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic waitFor(input string nm, ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      cyc(1);
      n++;
    end
    chk(nm, v, s);
  endtask

  task automatic halfPer(input int half);
    logic p;
    int n;
    repeat (2)
    begin
      p = strobeOut;
      n = 0;
      while (strobeOut === p && n < 300)
      begin
        cyc(1);
        n++;
      end
    end
    chk("strobe half period", 16'(half), 16'(n));
  endtask

  task automatic configure(input logic [2:0] m, input logic s);
    strap = '{modeA: m[0], modeB: m[1], modeC: m[2], oscSel: s};
    program_restart_n = 1'b0;
    cyc(4);
    chk("scan reset", 1'b1, scanReset);
    program_restart_n = 1'b1;
    waitFor("wait pin release", initOe, 1'b0, 100);
    cyc(6);
    chk("mode", m, latchedMode);
    chk("speed", s, slowOsc);
    chk("strobe drive", !(m inside {ccp_pkg::MODE_SLAVE_SER, ccp_pkg::MODE_SYNC_PERIPH,
      ccp_pkg::MODE_SLAVE_PAR}), strobeOe);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_total++;
    results();
  end

  initial
  begin
    cyc(4);
    chk("wait pin drive", 1'b1, initOe);
    chk("done drive", 1'b1, doneOe);
    chk("user pullup", 1'b1, userIoPullup);
    chk("unused pullup", 1'b1, unusedPinPullup);
    reset_n = 1'b1;
    initHold = 1'b1;
    strap = '{modeA: 1'b1, modeB: 1'b0, modeC: 1'b0, oscSel: 1'b0};
    cyc(120);
    chk("held off", 1'b0, strobeOe);
    initHold = 1'b0;
    cyc(6);
    chk("strobe drive", 1'b1, strobeOe);
    $display("test hold-off done");
    foreach (modes[i])
    begin
      configure(modes[i], i[0]);
      if (strobeOe === 1'b1)
        halfPer(i[0] ? ccp_pkg::HALF_SLOW : ccp_pkg::HALF_FAST);
      else
      begin
        edgeBase = edgeCnt;
        hostRun = 1'b1;
        cyc(80);
        hostRun = 1'b0;
        cyc(10);
        chk("strobe edges", 16'h0004, 16'(edgeCnt - edgeBase));
      end
      $display("test mode %h done", modes[i]);
    end
    trigReq_n = 1'b0;
    cyc(5);
    chk("tristate in config", 1'b1, global_tristate);
    trigReq_n = 1'b1;
    resetPin = 1'b0;
    cyc(5);
    chk("restart by reset pin", 1'b1, initOe);
    resetPin = 1'b1;
    waitFor("wait pin release", initOe, 1'b0, 100);
    cyc(6);
    doneHold = 1'b1;
    loadComplete = 1'b1;
    cyc(1);
    loadComplete = 1'b0;
    cyc(20);
    chk("done released", 1'b0, doneOe);
    chk("start-up held", 1'b0, configDone);
    doneHold = 1'b0;
    waitFor("config done", configDone, 1'b1, 20);
    $display("test start-up done");
    readbackEnable = 1'b1;
    trigReq_n = 1'b0;
    waitFor("readback start", readbackActive, 1'b1, 20);
    chk("readback frame", ccp_pkg::FRAME_START, readbackFrame);
    chk("no tristate", 1'b0, global_tristate);
    chk("readback data idle", 1'b0, readbackData);
    hostRun = 1'b1;
    cyc(80);
    hostRun = 1'b0;
    cyc(10);
    chk("readback frame count", 16'h0004, readbackFrame);
    chk("readback data", 1'b1, readbackData);
    trigReq_n = 1'b1;
    readbackEnable = 1'b0;
    cyc(5);
    trigReq_n = 1'b0;
    cyc(5);
    chk("tristate option", 1'b1, global_tristate);
    trigReq_n = 1'b1;
    scanSelect = 1'b1;
    scanTdo = 1'b1;
    cyc(1);
    chk("scan data", 1'b1, readbackData);
    scanTdo = 1'b0;
    cyc(1);
    chk("scan data", 1'b0, readbackData);
    resetPin = 1'b0;
    cyc(5);
    chk("cell clear", 1'b0, cellClear_n);
    chk("no restart", 1'b1, configDone);
    resetPin = 1'b1;
    $display("test readback done");
    results();
  end
endmodule
